// >>> logic/core_decode_pkg.sv
// Purpose: shared constants and types for the instruction decoder
// Assumes: 14-bit instruction words, 8-bit data, 16-bit pointers
// Notes:   opcodes held as whole-word values and upper-bit prefix matches
package core_decode_pkg;

  localparam int IW_W   = 14;
  localparam int DW     = 8;
  localparam int PTR_W  = 16;
  localparam int PC_W   = 15;
  localparam int FA_W   = 7;

  // fixed whole-word opcodes
  localparam logic [13:0] OP_NOP     = 14'h0000;
  localparam logic [13:0] OP_SWRESET = 14'h0001;
  localparam logic [13:0] OP_CALL_BY_WORKING_REG   = 14'h000a;
  localparam logic [13:0] OP_BRW     = 14'h000b;
  localparam logic [13:0] OP_OPTLOAD = 14'h0062;
  localparam logic [13:0] OP_STANDBY = 14'h0063;

  // prefix matches, compared against the upper bits shown
  localparam logic [9:0]  PFX_IND_MOVE = 10'h001;   // iw[13:4]
  localparam logic [5:0]  PFX_RETLIT   = 6'h34;     // iw[13:8]
  localparam logic [6:0]  PFX_ADDPTR   = 7'h62;     // iw[13:7]
  localparam logic [5:0]  PFX_INDEXED  = 6'h3f;     // iw[13:8]
  localparam logic [2:0]  PFX_JUMP     = 3'h5;      // iw[13:11]
  localparam logic [5:0]  PFX_LITOR    = 6'h38;     // iw[13:8]
  localparam logic [5:0]  PFX_REGOR    = 6'h04;     // iw[13:8]
  localparam logic [5:0]  PFX_INCREMENT_FILE     = 6'h0a;     // iw[13:8]
  localparam logic [5:0]  PFX_DECSKIP  = 6'h0b;     // iw[13:8]
  localparam logic [5:0]  PFX_INCSKIP  = 6'h0f;     // iw[13:8]

  // field positions
  localparam int FLD_DEST   = 7;
  localparam int FLD_PSEL   = 6;
  localparam int FLD_IPSEL  = 2;
  localparam int FLD_WRDIR  = 3;

  // modifier encodings
  localparam logic [1:0] MOD_PRE_INC  = 2'h0;
  localparam logic [1:0] MOD_PRE_DEC  = 2'h1;
  localparam logic [1:0] MOD_POST_INC = 2'h2;
  localparam logic [1:0] MOD_POST_DEC = 2'h3;

  localparam logic [7:0]  W_RESET    = 8'h00;
  localparam logic [7:0]  OPT_RESET  = 8'hff;
  localparam logic [15:0] PTR_RESET  = 16'h0000;
  localparam logic [14:0] PC_RESET   = 15'h0000;
  localparam logic [13:0] FETCH_NOP  = 14'h0000;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01,
    ST_XTRA  = 2'b10,
    ST_HALT  = 2'b11
  } exec_state_e;

  // data-file request issued by the decoder
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [PTR_W-1:0]  addr;
    logic              ind;
    logic [DW-1:0]     wdata;
  } file_req_s;

endpackage : core_decode_pkg

// >>> logic/fetch_latch.sv
// Purpose: holds the prefetched instruction word
// Assumes: program memory data valid in the cycle of its fetch
// Notes:   a flush swaps the word for a no-op
`timescale 1ns/1ps
`default_nettype none
module fetch_latch
  import core_decode_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            ce,
  input  wire logic            load,
  input  wire logic            flush,
  input  wire logic [IW_W-1:0] word_in,
  output logic      [IW_W-1:0] word_out
);

  logic [IW_W-1:0] next_word;

  always_comb begin
    next_word = word_out;
    if (flush)
      next_word = FETCH_NOP;
    else if (load)
      next_word = word_in;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      word_out <= FETCH_NOP;
    else if (ce)
      word_out <= next_word;
  end

endmodule : fetch_latch
`default_nettype wire

// >>> logic/insn_decoder.sv
// Purpose: decode and execute 14-bit core instruction words
// Assumes: file reads return data combinationally in the same cycle
// Notes:   one instruction cycle per sys_clk with ce high
//
// Function
// - standby, software reset, no-op take one cycle
// - option load copies W, flags untouched
// - branch by W takes two cycles
// - call by W takes two cycles
// - return with literal loads W, two cycles
// - add literal to selected pointer, one cycle
// - indirect read move updates zero flag
// - indirect write move leaves flags alone
// - indexed read at pointer plus signed offset
// - indexed write at pointer plus signed offset
// - pc change or true skip adds no-op
// - accessed address top bit set adds a cycle, except on a true skip
// - skip-on-zero stores result, no flags
// - dest bit picks W or file
// - jump loads low eleven bits plus page
// - literal or into W sets zero
// - register or to destination sets zero
// - increment file to destination sets zero
// - modifier codes select pre/post inc/dec
// - indirect register redirects to pointed address
// - pointers wrap across full sixteen bits
// - pointer modification leaves flags alone
`timescale 1ns/1ps
`default_nettype none
module insn_decoder
  import core_decode_pkg::*;
#(
  parameter int IND0_ADDR = 0,
  parameter int IND1_ADDR = 1
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            ce,
  input  wire logic [IW_W-1:0] prog_data,
  input  wire logic [DW-1:0]   file_rdata,
  input  wire logic [DW-1:0]   page_latch_register,
  output logic      [PC_W-1:0] prog_addr,
  output file_req_s            file_req,
  output logic      [DW-1:0]   work_reg,
  output logic      [DW-1:0]   option_reg,
  output logic      [PTR_W-1:0] ptr0,
  output logic      [PTR_W-1:0] ptr1,
  output logic                 zero_flag,
  output logic                 standby,
  output logic                 soft_reset,
  output logic      [PC_W-1:0] ret_addr
);

  exec_state_e      state;
  exec_state_e      next_state;
  logic [IW_W-1:0]  iw;
  logic [PC_W-1:0]  pc;
  logic [PC_W-1:0]  next_pc;
  logic [PC_W-1:0]  stack_top;
  logic [PC_W-1:0]  next_stack_top;
  logic [DW-1:0]    next_w;
  logic [DW-1:0]    next_opt;
  logic [PTR_W-1:0] next_p0;
  logic [PTR_W-1:0] next_p1;
  logic             next_z;
  logic             next_standby;
  logic             next_soft_reset;
  file_req_s        next_req;
  logic             flush;
  logic             load_fetch;

  // decoded classes
  logic is_ind_move;
  logic is_indexed;
  logic is_addptr;
  logic sel_ptr;
  logic [PTR_W-1:0] cur_ptr;
  logic [PTR_W-1:0] eff_addr;
  logic [PTR_W-1:0] ptr_after;
  logic [FA_W-1:0]  faddr;
  logic             f_is_ind;
  logic             f_ind_sel;

  function automatic logic [DW-1:0] lo_byte(input logic [IW_W-1:0] w);
    lo_byte = w[7:0];
  endfunction : lo_byte

  always_comb begin
    // bit 3 carries the direction, so it stays out of the match
    is_ind_move = (iw[13:4] == PFX_IND_MOVE);
    is_indexed  = (iw[13:8] == PFX_INDEXED);
    is_addptr   = (iw[13:7] == PFX_ADDPTR);
    sel_ptr     = is_ind_move ? iw[FLD_IPSEL] : iw[FLD_PSEL];
    faddr       = iw[FA_W-1:0];
    // file address 0/1 names an indirect data register
    f_is_ind    = (faddr == FA_W'(IND0_ADDR)) ||
                  (faddr == FA_W'(IND1_ADDR));
    f_ind_sel   = (faddr == FA_W'(IND1_ADDR));
    if (is_ind_move || is_indexed || is_addptr)
      cur_ptr = sel_ptr ? ptr1 : ptr0;
    else
      cur_ptr = f_ind_sel ? ptr1 : ptr0;
  end

  pointer_math u_ptr (
    .ptr            (cur_ptr),
    .modifier_field (iw[1:0]),
    .offset         (iw[5:0]),
    .indexed        (is_indexed),
    .add_only       (is_addptr),
    .eff_addr       (eff_addr),
    .ptr_after      (ptr_after)
  );

  fetch_latch u_fetch (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .load     (load_fetch),
    .flush    (flush),
    .word_in  (prog_data),
    .word_out (iw)
  );

  always_comb begin
    logic [DW-1:0] res;
    logic          to_file;
    logic          ind_access;
    res             = '0;
    to_file         = 1'b0;
    ind_access      = 1'b0;
    next_state      = state;
    next_pc         = pc;
    next_stack_top  = stack_top;
    next_w          = work_reg;
    next_opt        = option_reg;
    next_p0         = ptr0;
    next_p1         = ptr1;
    next_z          = zero_flag;
    next_standby    = standby;
    next_soft_reset = 1'b0;
    next_req        = '0;
    flush           = 1'b0;
    load_fetch      = 1'b0;
    case (state)
      ST_EXEC: begin
        load_fetch = 1'b1;                      // prefetch
        next_pc    = PC_W'(pc + 15'h0001);
        if (iw == OP_NOP) begin
          next_state = ST_EXEC;
        end else if (iw == OP_STANDBY) begin
          next_standby = 1'b1;
          next_state   = ST_HALT;
        end else if (iw == OP_SWRESET) begin
          next_soft_reset = 1'b1;
        end else if (iw == OP_OPTLOAD) begin
          next_opt = work_reg;                  // no flag change
        end else if (iw == OP_BRW) begin
          next_pc = PC_W'(pc + {7'h00, work_reg});
          flush   = 1'b1;
        end else if (iw == OP_CALL_BY_WORKING_REG) begin
          next_stack_top = pc;
          next_pc = {page_latch_register[6:0], work_reg};
          flush   = 1'b1;
        end else if (iw[13:8] == PFX_RETLIT) begin
          next_w  = lo_byte(iw);
          next_pc = stack_top;
          flush   = 1'b1;
        end else if (iw[13:11] == PFX_JUMP) begin
          next_pc = {page_latch_register[6:3], iw[10:0]};
          flush   = 1'b1;
        end else if (is_addptr) begin
          if (sel_ptr) next_p1 = ptr_after;
          else next_p0 = ptr_after;
        end else if (is_ind_move || is_indexed) begin
          next_req.addr = eff_addr;
          next_req.ind  = 1'b1;
          ind_access    = eff_addr[PTR_W-1];
          if (is_ind_move) begin
            if (sel_ptr) next_p1 = ptr_after;
            else next_p0 = ptr_after;
          end
          if ((is_ind_move && iw[FLD_WRDIR]) ||
              (is_indexed && iw[FLD_DEST])) begin
            next_req.wr    = 1'b1;              // flags kept
            next_req.wdata = work_reg;
          end else begin
            next_req.rd = 1'b1;
            next_w = file_rdata;
            next_z = (file_rdata == 8'h00);
          end
        end else if (iw[13:8] == PFX_LITOR) begin
          next_w = work_reg | lo_byte(iw);
          next_z = (next_w == 8'h00);
        end else if (iw[13:8] == PFX_REGOR || iw[13:8] == PFX_INCREMENT_FILE ||
                     iw[13:8] == PFX_DECSKIP ||
                     iw[13:8] == PFX_INCSKIP) begin
          to_file = iw[FLD_DEST];
          if (iw[13:8] == PFX_REGOR)
            res = work_reg | file_rdata;
          else if (iw[13:8] == PFX_DECSKIP)
            res = DW'(file_rdata - 8'h01);
          else
            res = DW'(file_rdata + 8'h01);
          if (iw[13:8] == PFX_REGOR || iw[13:8] == PFX_INCREMENT_FILE)
            next_z = (res == 8'h00);
          else if (res == 8'h00)
            flush = 1'b1;                       // skip
          next_req.rd = 1'b1;
          next_req.ind = f_is_ind;
          next_req.addr = f_is_ind ? cur_ptr : {9'h000, faddr};
          ind_access = f_is_ind && cur_ptr[PTR_W-1];
          if (to_file) begin                    // dest bit
            next_req.wr    = 1'b1;
            next_req.wdata = res;
          end else begin
            next_w = res;
          end
        end
        if (flush)
          next_state = ST_FLUSH;
        else if (ind_access) begin
          next_state = ST_XTRA;
          next_pc    = pc;
          load_fetch = 1'b0;
        end
      end
      ST_FLUSH: begin
        // second cycle runs as no-op while refetching
        load_fetch = 1'b1;
        next_pc    = PC_W'(pc + 15'h0001);
        next_state = ST_EXEC;
      end
      ST_XTRA: begin
        load_fetch = 1'b1;
        flush      = 1'b0;
        next_pc    = PC_W'(pc + 15'h0001);
        next_state = ST_EXEC;
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
      default: next_state = ST_EXEC;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state      <= ST_EXEC;
      pc         <= PC_RESET;
      stack_top  <= PC_RESET;
      work_reg   <= W_RESET;
      option_reg <= OPT_RESET;
      ptr0       <= PTR_RESET;
      ptr1       <= PTR_RESET;
      zero_flag  <= 1'b0;
      standby    <= 1'b0;
      soft_reset <= 1'b0;
      file_req   <= '0;
    end else if (ce) begin
      state      <= next_state;
      pc         <= next_pc;
      stack_top  <= next_stack_top;
      work_reg   <= next_w;
      option_reg <= next_opt;
      ptr0       <= next_p0;
      ptr1       <= next_p1;
      zero_flag  <= next_z;
      standby    <= next_standby;
      soft_reset <= next_soft_reset;
      file_req   <= next_req;
    end
  end

  always_comb begin
    prog_addr = pc;
    ret_addr  = stack_top;
  end

  // assertions
  chk_nop_single: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && iw == OP_NOP)
      |=> state == ST_EXEC && pc == PC_W'($past(pc) + 15'h0001))
    else $error("no-op did not complete in one cycle");

  chk_standby_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && iw == OP_STANDBY) |=> standby)
    else $error("standby not entered");

  chk_option_copy: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && iw == OP_OPTLOAD)
      |=> option_reg == $past(work_reg) && zero_flag == $past(zero_flag))
    else $error("option load wrong");

  sequence branch_taken;
    ce && state == ST_EXEC && (iw == OP_BRW || iw == OP_CALL_BY_WORKING_REG ||
      iw[13:11] == PFX_JUMP);
  endsequence

  chk_branch_two: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    branch_taken |=> state == ST_FLUSH)
    else $error("branch did not take two cycles");

  chk_jump_target: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && iw[13:11] == PFX_JUMP)
      |=> pc[10:0] == $past(iw[10:0]))
    else $error("jump target wrong");

  chk_litor_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && iw[13:8] == PFX_LITOR)
      |=> work_reg == ($past(work_reg) | $past(iw[7:0])) &&
          zero_flag == (work_reg == 8'h00))
    else $error("literal or result wrong");

  chk_write_flags: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && is_ind_move && iw[FLD_WRDIR])
      |=> zero_flag == $past(zero_flag) && file_req.wr)
    else $error("indirect write touched flags");

  chk_retlit_w: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && iw[13:8] == PFX_RETLIT)
      |=> work_reg == $past(iw[7:0]) && state == ST_FLUSH)
    else $error("return with literal wrong");

  chk_extra_cycle: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && (is_ind_move || is_indexed) &&
     eff_addr[PTR_W-1]) |=> state == ST_XTRA)
    else $error("no extra cycle for high pointer");

  chk_skip_flags: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC &&
     (iw[13:8] == PFX_DECSKIP || iw[13:8] == PFX_INCSKIP))
      |=> zero_flag == $past(zero_flag))
    else $error("skip instruction touched flags");

  chk_addptr_one: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (ce && state == ST_EXEC && is_addptr)
      |=> state == ST_EXEC && zero_flag == $past(zero_flag))
    else $error("pointer add not single cycle or touched flags");

endmodule : insn_decoder
`default_nettype wire

// >>> logic/pointer_math.sv
// Purpose: indirect pointer arithmetic for moves and adds
// Assumes: 16-bit pointers, wrapping at both ends
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module pointer_math
  import core_decode_pkg::*;
(
  input  wire logic [PTR_W-1:0] ptr,
  input  wire logic [1:0]       modifier_field,
  input  wire logic [5:0]       offset,
  input  wire logic             indexed,
  input  wire logic             add_only,
  output logic      [PTR_W-1:0] eff_addr,
  output logic      [PTR_W-1:0] ptr_after
);

  logic [PTR_W-1:0] step;
  logic [PTR_W-1:0] sext;

  always_comb begin
    sext = {{(PTR_W-6){offset[5]}}, offset};
    step = modifier_field[0] ? 16'hffff : 16'h0001;
    // modulo 2^16 sums give the wrap at both bounds
    if (indexed) begin
      eff_addr  = PTR_W'(ptr + sext);
      ptr_after = ptr;
    end else if (add_only) begin
      eff_addr  = ptr;
      ptr_after = PTR_W'(ptr + {10'h000, offset});
    end else if (!modifier_field[1]) begin
      eff_addr  = PTR_W'(ptr + step);   // pre forms
      ptr_after = eff_addr;
    end else begin
      eff_addr  = ptr;                  // post forms
      ptr_after = PTR_W'(ptr + step);
    end
  end

endmodule : pointer_math
`default_nettype wire

// >>> verification/prog_mem_model.sv
// Purpose: program memory seen by the decoder
// Assumes: word readable in the cycle its address is shown
// Notes:   unloaded words read as no-op; bench loads words directly
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
  import core_decode_pkg::*;
(
  input  wire logic [PC_W-1:0] prog_addr,
  output logic      [IW_W-1:0] prog_data
);
  logic [IW_W-1:0] mem [0:(1<<PC_W)-1];

  task automatic clear();
    foreach (mem[i]) mem[i] = OP_NOP;
  endtask : clear

  // combinational read so the next word is ready while one executes
  assign prog_data = mem[prog_addr];
endmodule : prog_mem_model
`default_nettype wire

// >>> verification/tb_insn_decoder.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: file read data held constant through each short program
// Notes:   cycle counts taken relative to a lone standby program
`timescale 1ns/1ps
`default_nettype none
module tb_insn_decoder;
  import core_decode_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             ce = 1'b1;
  logic [DW-1:0]    file_rdata = 8'h00;
  logic [DW-1:0]    page_latch_register = 8'h00;
  logic [IW_W-1:0]  prog_data;
  logic [PC_W-1:0]  prog_addr;
  logic [PC_W-1:0]  ret_addr;
  file_req_s        file_req;
  logic [DW-1:0]    work_reg;
  logic [DW-1:0]    option_reg;
  logic [PTR_W-1:0] ptr0;
  logic [PTR_W-1:0] ptr1;
  logic             zero_flag;
  logic             standby;
  logic             soft_reset;
  integer           seed = 32'h0381698f;
  int               err_count = 0;
  int               n_compared = 0;
  int               ticks = 0;
  int               cyc;
  int               base;
  int               wr_n;
  int               sr_n;
  logic [15:0]      wr_addr;
  logic [15:0]      rd_addr;
  logic [7:0]       wr_data;
  logic             ind_seen;

  always #12.5 sys_clk = ~sys_clk;

  insn_decoder insn_decoder_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .prog_data(prog_data),
    .file_rdata(file_rdata), .page_latch_register(page_latch_register),
    .prog_addr(prog_addr), .file_req(file_req), .work_reg(work_reg),
    .option_reg(option_reg), .ptr0(ptr0), .ptr1(ptr1),
    .zero_flag(zero_flag), .standby(standby), .soft_reset(soft_reset),
    .ret_addr(ret_addr)
  );

  prog_mem_model prog_mem_model_inst (
    .prog_addr(prog_addr),
    .prog_data(prog_data)
  );

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // runs far beyond the under one thousand cycles the programs need
  always @(posedge sys_clk) begin
    ticks++;
    if (ticks == 20000) begin
      err_count++;
      test_done();
    end
  end

  function automatic logic [7:0] r8();
    return 8'($random(seed));
  endfunction : r8

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ld(logic [13:0] a, b, c, d);
    prog_mem_model_inst.clear();
    prog_mem_model_inst.mem[0] = a;
    prog_mem_model_inst.mem[1] = b;
    prog_mem_model_inst.mem[2] = c;
    prog_mem_model_inst.mem[3] = d;
  endtask : ld

  // reset, then run with random ce until standby; only enabled edges count
  task automatic go(logic [7:0] rd, logic [7:0] pg);
    int   guard;
    logic on;
    guard = 0;
    @(posedge sys_clk);
    file_rdata <= rd;
    page_latch_register <= pg;
    rst_b <= 1'b0;
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc = 0;
    wr_n = 0;
    sr_n = 0;
    while (standby !== 1'b1 && guard < 300) begin
      @(posedge sys_clk);
      guard++;
      on = ce;
      ce <= ((r8() & 8'h03) != 8'h00);
      #1;
      if (on === 1'b1) begin
        cyc++;
        if (file_req.wr === 1'b1) begin
          wr_n++;
          wr_addr = file_req.addr;
          wr_data = file_req.wdata;
        end
        if (file_req.rd === 1'b1) rd_addr = file_req.addr;
        if ((file_req.rd | file_req.wr) === 1'b1)
          ind_seen = file_req.ind;
        if (soft_reset === 1'b1) sr_n++;
      end
    end
    // a program that never halts is a failure, not a silent skip
    if (standby !== 1'b1) begin
      err_count++;
      $display("Error standby expected 1 seen %b", standby);
    end
  endtask : go

  initial begin
    logic [7:0]  w, rd, res, pg, k;
    logic [5:0]  k6, pf;
    logic [15:0] p, eff, aft;
    logic [10:0] t11;
    logic [14:0] t;
    logic        n, wr, d, skp;
    logic [1:0]  mm, op;
    ld(OP_STANDBY, OP_NOP, OP_NOP, OP_NOP);
    go(8'h00, 8'h00);
    base = cyc;
    chk("option reset", 16'h00ff, 16'(option_reg));
    for (int i = 0; i < 8; i++) begin
      k = (i == 0) ? 8'h00 : r8();
      ld(OP_NOP, {6'h38, k}, OP_OPTLOAD, OP_STANDBY);
      go(r8(), r8());
      chk("cycles", 16'(base + 3), 16'(cyc));
      chk("w", 16'(k), 16'(work_reg));
      chk("option", 16'(k), 16'(option_reg));
      chk("zero", 16'(k == 0), 16'(zero_flag));
      chk("soft reset", 16'h0000, 16'(sr_n));
    end
    // 0..15 pointer moves, 16..23 indexed moves
    for (int i = 0; i < 24; i++) begin
      n = i[0];
      wr = (i < 16) ? i[3] : i[1];
      mm = i[2:1];
      p = (i < 16 && mm == 2'h1) ? 16'h0000 : 16'(r8() & 8'h1f);
      w = (i < 2) ? 8'h00 : r8();
      rd = (i == 4) ? 8'h00 : r8();
      k6 = (i == 18) ? 6'h20 : (i == 19) ? 6'h1f : 6'(r8());
      aft = mm[0] ? p - 16'h1 : p + 16'h1;
      eff = mm[1] ? p : aft;
      if (i >= 16) begin
        aft = p;
        eff = p + {{10{k6[5]}}, k6};
      end
      ld({7'h62, n, p[5:0]}, {6'h38, w},
         (i < 16) ? {10'h001, wr, n, mm} : {6'h3f, wr, n, k6}, OP_STANDBY);
      go(rd, r8());
      chk("cycles", 16'(base + 3 + eff[15]), 16'(cyc));
      chk("pointer", aft, n ? ptr1 : ptr0);
      chk("writes", 16'(wr), 16'(wr_n));
      chk("ind", 16'h0001, 16'(ind_seen));
      if (wr) begin
        chk("wr addr", eff, wr_addr);
        chk("wr data", 16'(w), 16'(wr_data));
        chk("zero", 16'(w == 0), 16'(zero_flag));
      end else begin
        chk("rd addr", eff, rd_addr);
        chk("w", 16'(rd), 16'(work_reg));
        chk("zero", 16'(rd == 0), 16'(zero_flag));
      end
    end
    // op 0 increment, 1 or, 2 decrement-skip, 3 increment-skip
    for (int i = 0; i < 16; i++) begin
      op = i[2:1];
      d = i[0];
      rd = (op == 2'h2) ? 8'h01 : (op == 2'h1) ? 8'h00 : 8'hff;
      rd = (i < 8) ? rd : r8();
      w = (i < 8 && op == 2'h1) ? 8'h00 : (r8() | 8'h01);
      pf = (op == 2'h0) ? 6'h0a : (op == 2'h1) ? 6'h04 : 6'h0b;
      pf = (op == 2'h3) ? 6'h0f : pf;
      res = (op == 2'h1) ? (w | rd) : (op == 2'h2) ? rd - 8'h1 : rd + 8'h1;
      skp = op[1] && res == 8'h00;
      k = 8'h20 + (r8() & 8'h3f);
      ld({6'h38, w}, {pf, d, k[6:0]}, OP_OPTLOAD, OP_STANDBY);
      go(rd, r8());
      chk("cycles", 16'(base + 3), 16'(cyc));
      chk("w", 16'(d ? w : res), 16'(work_reg));
      chk("option", 16'(skp ? 8'hff : d ? w : res), 16'(option_reg));
      chk("zero", 16'(op[1] ? w == 0 : res == 0), 16'(zero_flag));
      chk("writes", 16'(d), 16'(wr_n));
      chk("ind", 16'h0000, 16'(ind_seen));
      if (d) begin
        chk("wr addr", 16'(k[6:0]), wr_addr);
        chk("wr data", 16'(res), 16'(wr_data));
      end
    end
    for (int i = 0; i < 4; i++) begin
      pg = r8();
      k = r8();
      // keep the target pair clear of the program at word zero
      t11 = (11'($random(seed)) & 11'h7fe) | 11'h008;
      t = {pg[6:3], t11};
      ld({3'h5, t11}, {6'h38, 8'haa}, OP_STANDBY, OP_NOP);
      prog_mem_model_inst.mem[t] = {6'h38, k};
      prog_mem_model_inst.mem[t + 15'h1] = OP_STANDBY;
      go(r8(), pg);
      chk("jump cycles", 16'(base + 3), 16'(cyc));
      chk("jump w", 16'(k), 16'(work_reg));
      w = 8'h01 + (r8() % 8'd40);
      ld({6'h38, w}, OP_BRW, {6'h38, 8'haa}, OP_NOP);
      prog_mem_model_inst.mem[2 + w] = OP_STANDBY;
      go(r8(), pg);
      chk("branch cycles", 16'(base + 3), 16'(cyc));
      chk("branch w", 16'(w), 16'(work_reg));
      w = 8'h10 + (r8() % 8'he0);
      ld({6'h38, w}, OP_CALL_BY_WORKING_REG, OP_STANDBY, OP_NOP);
      prog_mem_model_inst.mem[{pg[6:0], w}] = {6'h34, k};
      go(r8(), pg);
      chk("call cycles", 16'(base + 5), 16'(cyc));
      chk("ret w", 16'(k), 16'(work_reg));
      chk("ret addr", 16'h0002, 16'(ret_addr));
    end
    ld(OP_SWRESET, OP_STANDBY, OP_NOP, OP_NOP);
    go(r8(), r8());
    chk("soft reset", 16'h0001, 16'(sr_n));
    test_done();
  end
endmodule : tb_insn_decoder
`default_nettype wire
